// File: acs_defines.svh
/*
  Timing counts, trigger select codes and field constants for the
  conversion sequencer. Assumes inclusion by bare name.
*/
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// Conversion length in half conversion clocks (11.5 periods)
`define ACS_CONV_HALF_TADS   5'd23
// Trigger select codes
`define ACS_TRIG_OFF         5'h00
`define ACS_TRIG_PIN         5'h01
`define ACS_TRIG_LAST_PERIPH 5'h17
`define ACS_TRIG_ERRH_READ   5'h1c
`define ACS_TRIG_RESH_READ   5'h1d
`define ACS_TRIG_CHAN_WRITE  5'h1f
// Result width
`define ACS_RES_W            10
// Reset values
`define ACS_RESET_RESULT     10'h000
`define ACS_RESET_ACC        16'h0000

`endif

// File: acs_far_model.sv
/* Far side: remapped pin, peripheral triggers, RC clock, analog code.
   Assumes the bench holds fire for several mclk cycles. */
`timescale 1ns/1ps
`default_nettype none
module acs_far_model (
  // Bench side
  input  wire logic       mclk,
  input  wire logic       fire,
  input  wire logic [4:0] fire_code,
  input  wire logic [9:0] code_in,
  // Device side
  output logic            trigger_pin_remap,
  output logic [21:0]     periph_trig,
  output logic            rc_tick,
  output logic [9:0]      sar_code
);
  // Free RC oscillator, unrelated in phase to mclk
  initial begin
    rc_tick = 1'b0;
    forever #55 rc_tick = ~rc_tick;
  end
  // Only the source that the code picks rises
  always @(posedge mclk) begin
    trigger_pin_remap <= fire && fire_code == 5'h01;
    periph_trig <= (fire && fire_code inside {[5'h02:5'h17]})
      ? 22'h000001 << (fire_code - 5'h02) : 22'h000000;
  end
  // Code holds steady through a conversion
  assign sar_code = code_in;
endmodule : acs_far_model
`default_nettype wire

// File: acs_pkg.sv
/*
  Types for the conversion sequencer.
  Assumes acs_defines.svh is on the include path.
*/
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_DELAY = 2'b01,
    ACS_CONV  = 2'b10
  } acs_state_t;
endpackage : acs_pkg

// File: acs_sequencer.sv
/*
  Conversion sequencer for a 10-bit successive-approximation converter:
  start sources, completion updates, abort, sleep handling.
  Assumes the analog core delivers its code on sar_code when a
  conversion ends, and that software bits arrive as mclk-domain levels
  and one-cycle pulses; trigger sources and rc_tick are asynchronous.
  The half-tick counter and its divider run only while converting.
*/
// Operation
// - done flag sets at every conversion end, regardless of enable.
// - with interrupt enabled in sleep, completion raises wake request.
// - converting in sleep only with internal RC conversion clock.
// - result placed left or right justified per result_justify.
// - nothing converts while module_on is low.
// - start by go write, hardware trigger or continuous retrigger.
// - previous_source_select 0 copies old result to previous register.
// - at end clear go unless continuous; set flags, update accumulator.
// - error and threshold test every conversion, or every second.
// - threshold evaluation follows completion; handlers check flag first.
// - clearing go mid-conversion aborts; result keeps old value.
// - reset clears all registers, module off, conversion abandoned.
// - RC clock delays conversion start by one instruction cycle.
// - in sleep with interrupt disabled, power down after completion.
// - trigger in sleep with RC clock converts and sets done flag.
// - trigger in sleep without RC clock waits pending until wake.
// - rising edge of selected trigger sets go bit.
// - codes 0 off, 1f channel write, 1d result read, 1c error read.
// - code 1 trigger pin, codes 2 to 17 peripheral sources.
// - a conversion lasts eleven and a half conversion clocks.
// - clock_source_select 1 picks RC clock, 0 divided system clock.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module acs_sequencer import acs_pkg::*; #(
  parameter int DIV_W    = 6,
  parameter int N_PERIPH = 22,
  parameter int INSTR_CYCLES = 4
) (
  // Clock, reset and clock enable
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  // Software control
  input  wire logic                 module_on,
  input  wire logic                 go_set,
  input  wire logic                 go_clear,
  input  wire logic                 continuous_mode,
  input  wire logic                 result_justify,
  input  wire logic                 previous_source_select,
  input  wire logic                 double_sample_enable,
  input  wire logic                 clock_source_select,
  input  wire logic [DIV_W-1:0]     clock_divider,
  input  wire logic [4:0]           trigger_select,
  input  wire logic                 conv_irq_enable,
  input  wire logic                 conv_done_clear,
  input  wire logic                 threshold_clear,
  input  wire logic                 computation_clear,
  input  wire logic [9:0]           threshold_setpoint,
  input  wire logic                 sleeping,
  // Software access events for trigger codes
  input  wire logic                 chan_write_evt,
  input  wire logic                 result_high_read_evt,
  input  wire logic                 error_high_read_evt,
  // Asynchronous trigger sources and RC clock tick
  input  wire logic                 trigger_pin_remap,
  input  wire logic [N_PERIPH-1:0]  periph_trig,
  input  wire logic                 rc_tick,
  // Analog core
  input  wire logic [9:0]           sar_code,
  // Status and results
  output logic                      go_bit,
  output logic                      conv_done_flag,
  output logic                      computation_pending,
  output logic                      threshold_flag,
  output logic                      wake_request,
  output logic                      converter_powered,
  output logic [15:0]               result_reg,
  output logic [15:0]               previous_result_reg,
  output logic [15:0]               accumulator_reg,
  output logic [15:0]               error_value_reg
);
  // One synchroniser bit for the remapped pin, one per peripheral source
  localparam int NA = N_PERIPH + 1;

  // Justify a raw code into the 16-bit result register pair
  function automatic logic [15:0] justify(input logic [9:0] c,
                                          input logic       left);
    justify = left ? {c, 6'h00} : {6'h00, c};
  endfunction : justify
  // Left keeps the code in the top ten bits, right in the bottom ten

  // Distance of a code from the setpoint, never negative
  function automatic logic [9:0] distance(input logic [9:0] a,
                                          input logic [9:0] b);
    distance = (a > b) ? a - b : b - a;
  endfunction : distance

  // Three-stage synchronisers for asynchronous sources
  // Stage one may go metastable; only stage two reads it, and the edge
  // detector below compares stages two and three
  logic [NA-1:0] s1, s2, s3;
  logic [2:0]    rc_s;
  always_ff @(posedge mclk) begin
    if (srst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      rc_s <= '0;
    end else if (ce) begin
      s1   <= {periph_trig, trigger_pin_remap};
      s2   <= s1;
      s3   <= s2;
      rc_s <= {rc_s[1:0], rc_tick};
    end
  end

  // Trigger selection, rising edge found where stage two is high and stage three low
  // Software access events are already on mclk and need no synchroniser
  logic sel_now, sel_old, sw_evt, trig_edge;
  always_comb begin
    sel_now = 1'b0;
    sel_old = 1'b0;
    if (trigger_select >= `ACS_TRIG_PIN &&
        trigger_select <= `ACS_TRIG_LAST_PERIPH) begin
      sel_now = s2[trigger_select - 5'd1];
      sel_old = s3[trigger_select - 5'd1];
    end
    unique case (trigger_select)
      `ACS_TRIG_CHAN_WRITE: sw_evt = chan_write_evt;
      `ACS_TRIG_RESH_READ:  sw_evt = result_high_read_evt;
      `ACS_TRIG_ERRH_READ:  sw_evt = error_high_read_evt;
      default:              sw_evt = 1'b0;
    endcase
    trig_edge = (sel_now & ~sel_old) | sw_evt;
  end

  // Conversion clock ticks only while a conversion runs, so every
  // conversion starts from a fresh divider phase
  logic half_tick;
  logic conv_run;
  acs_tad_gen #(.DIV_W(DIV_W)) u_tad (
    .mclk                (mclk),
    .srst                (srst),
    .ce                  (ce),
    .run                 (conv_run),
    .clock_source_select (clock_source_select),
    .clock_divider       (clock_divider),
    .rc_tick             (rc_s[2] ^ rc_s[1]),
    .half_tick           (half_tick)
  );

  // Conversion state, counters and next values
  acs_state_t state, next_state;
  logic [4:0]  half_cnt, next_half_cnt;
  logic [3:0]  dly_cnt, next_dly_cnt;
  logic        pend, next_pend;
  logic        odd, next_odd;
  logic        next_go, next_done, next_math, next_thr, next_wake, next_pwr;
  logic [15:0] next_res, next_prev, next_acc, next_err;
  logic        may_run, end_conv;
  logic [9:0]  err_abs;

  // The divider runs only in the converting state
  assign conv_run = (state == ACS_CONV);

  // Sequencer next state
  always_comb begin
    next_state    = state;
    next_half_cnt = half_cnt;
    next_dly_cnt  = dly_cnt;
    next_pend     = pend;
    next_odd      = odd;
    next_go       = go_bit;
    next_done     = conv_done_flag;
    next_math     = computation_pending;
    next_thr      = threshold_flag;
    next_wake     = 1'b0;
    next_pwr      = converter_powered;
    next_res      = result_reg;
    next_prev     = previous_result_reg;
    next_acc      = accumulator_reg;
    next_err      = error_value_reg;
    end_conv      = 1'b0;
    err_abs       = '0;
    may_run       = !sleeping || clock_source_select;
    // Software clears first so that hardware sets win
    if (conv_done_clear)   next_done = 1'b0;
    if (threshold_clear)   next_thr  = 1'b0;
    if (computation_clear) next_math = 1'b0;
    if (go_set) next_go = 1'b1;
    if (go_clear) next_go = 1'b0;
    if (trig_edge && module_on) begin
      if (may_run) next_go = 1'b1;
      else         next_pend = 1'b1;
    end
    // A trigger held through sleep starts once the converter may run
    if (pend && may_run) begin
      next_go   = 1'b1;
      next_pend = 1'b0;
    end
    // Module off overrides every start source and drops a held trigger
    if (!module_on) begin
      next_go    = 1'b0;
      next_pend  = 1'b0;
      next_pwr   = 1'b0;
      next_state = ACS_IDLE;
    end else begin
      if (!sleeping) next_pwr = 1'b1;
      unique case (state)
        // Start only if the selected clock may run in the present mode
        ACS_IDLE: begin
          if (next_go && may_run) begin
            next_pwr      = 1'b1;
            next_half_cnt = '0;
            next_dly_cnt  = '0;
            next_state    = clock_source_select ? ACS_DELAY
                                                : ACS_CONV;
          end
        end
        // Extra instruction cycle so a sleep can begin before converting
        ACS_DELAY: begin
          if (go_clear) next_state = ACS_IDLE;
          else if (dly_cnt == 4'(INSTR_CYCLES - 1))
            next_state = ACS_CONV;
          else next_dly_cnt = dly_cnt + 4'd1;
        end
        // Sleep without the RC clock abandons the conversion
        ACS_CONV: begin
          if (go_clear || !may_run) begin
            next_state = ACS_IDLE;
          end else if (half_tick) begin
            if (half_cnt == `ACS_CONV_HALF_TADS - 5'd1) begin
              end_conv   = 1'b1;
              next_state = ACS_IDLE;
            end else begin
              next_half_cnt = half_cnt + 5'd1;
            end
          end
        end
        default: next_state = ACS_IDLE;
      endcase
    end
    // Completion updates
    // The error test uses the parity before this conversion toggles it
    if (end_conv) begin
      if (!previous_source_select) next_prev = result_reg;
      next_res  = justify(sar_code, result_justify);
      if (!continuous_mode) next_go = 1'b0;
      next_done = 1'b1;
      next_math = 1'b1;
      next_acc  = accumulator_reg + {6'h00, sar_code};
      next_odd  = ~odd;
      if (!double_sample_enable || odd) begin
        err_abs  = distance(sar_code, threshold_setpoint);
        next_err = {6'h00, err_abs};
        if (err_abs > threshold_setpoint) next_thr = 1'b1;
      end
      if (sleeping && conv_irq_enable) next_wake = 1'b1;
      if (sleeping && !conv_irq_enable) next_pwr = 1'b0;
    end
  end

  // Registers; reset returns everything to idle and off
  // Clock enable low freezes every register, counters included
  always_ff @(posedge mclk) begin
    if (srst) begin
      state               <= ACS_IDLE;
      half_cnt            <= '0;
      dly_cnt             <= '0;
      pend                <= 1'b0;
      odd                 <= 1'b0;
      go_bit              <= 1'b0;
      conv_done_flag      <= 1'b0;
      computation_pending <= 1'b0;
      threshold_flag      <= 1'b0;
      wake_request        <= 1'b0;
      converter_powered   <= 1'b0;
      result_reg          <= {6'h00, `ACS_RESET_RESULT};
      previous_result_reg <= {6'h00, `ACS_RESET_RESULT};
      accumulator_reg     <= `ACS_RESET_ACC;
      error_value_reg     <= 16'h0000;
    end else if (ce) begin
      state               <= next_state;
      half_cnt            <= next_half_cnt;
      dly_cnt             <= next_dly_cnt;
      pend                <= next_pend;
      odd                 <= next_odd;
      go_bit              <= next_go;
      conv_done_flag      <= next_done;
      computation_pending <= next_math;
      threshold_flag      <= next_thr;
      wake_request        <= next_wake;
      converter_powered   <= next_pwr;
      result_reg          <= next_res;
      previous_result_reg <= next_prev;
      accumulator_reg     <= next_acc;
      error_value_reg     <= next_err;
    end
  end
endmodule : acs_sequencer
`default_nettype wire

// File: acs_sequencer_properties.sv
/* Checker on the ports of acs_sequencer, bound to every instance.
   Assumes one mclk domain with srst as synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module acs_seq_checker #(parameter int DIV_W = 6) (
  // Clock, reset and controls
  input wire logic             mclk,
  input wire logic             srst,
  input wire logic             module_on,
  input wire logic             go_clear,
  input wire logic             continuous_mode,
  input wire logic             result_justify,
  input wire logic             previous_source_select,
  input wire logic             conv_done_clear,
  input wire logic [DIV_W-1:0] clock_divider,
  input wire logic             clock_source_select,
  input wire logic [9:0]       sar_code,
  // Observed outputs
  input wire logic             go_bit,
  input wire logic             conv_done_flag,
  input wire logic             computation_pending,
  input wire logic             wake_request,
  input wire logic [15:0]      result_reg,
  input wire logic [15:0]      previous_result_reg
);
  logic        go_q;
  logic [15:0] run_cnt;
  logic [15:0] next_run_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Cycles since go last rose
  always_comb next_run_cnt = (go_bit && !go_q) ? 16'h0000 : run_cnt + 16'h0001;
  always_ff @(posedge mclk) begin
    go_q    <= go_bit;
    run_cnt <= next_run_cnt;
  end
  // Completion seen as the done flag rising
  sequence s_done_rise;
    $rose(conv_done_flag);
  endsequence
  a_off_holds_idle: assert property (
    !module_on |=> !go_bit) else $error("go set while module off");
  a_done_stays_set: assert property (
    conv_done_flag && !conv_done_clear && !srst |=> conv_done_flag)
    else $error("done flag dropped without clear");
  a_result_format: assert property (
    $changed(result_reg) && !$past(srst) |->
    result_reg == ($past(result_justify) ? {$past(sar_code), 6'h00}
    : {6'h00, $past(sar_code)})) else $error("result badly placed");
  a_previous_copy: assert property (
    $changed(result_reg) && !$past(previous_source_select) && !$past(srst)
    |-> previous_result_reg == $past(result_reg))
    else $error("previous result not copied");
  a_end_clears_go: assert property (
    s_done_rise ##0 !$past(continuous_mode) |-> !go_bit)
    else $error("go still set after completion");
  a_end_sets_math: assert property (
    s_done_rise |-> computation_pending) else $error("math bit not set");
  a_abort_drops_go: assert property (
    go_clear |=> !go_bit) else $error("abort left go set");
  a_conv_length: assert property (
    s_done_rise |->
    run_cnt >= 22 * (clock_source_select ? 1 : clock_divider + 1))
    else $error("conversion too short");
  a_wake_pulse: assert property (
    wake_request |-> conv_done_flag ##1 !wake_request)
    else $error("wake pulse wrong");
endmodule : acs_seq_checker
bind acs_sequencer acs_seq_checker #(.DIV_W(DIV_W)) u_chk (.mclk, .srst,
  .module_on, .go_clear, .continuous_mode, .result_justify,
  .previous_source_select, .conv_done_clear, .clock_divider, .sar_code,
  .clock_source_select,
  .go_bit, .conv_done_flag, .computation_pending, .wake_request,
  .result_reg, .previous_result_reg);
`default_nettype wire

// File: acs_tad_gen.sv
/*
  Conversion clock tick generator: a half-period tick either from the
  internal RC tick input or from a divided system clock.
  Assumes rc_tick is already synchronised to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_tad_gen #(
  parameter int DIV_W = 6
) (
  // Clock and control
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic             run,
  // Source selection
  input  wire logic             clock_source_select,
  input  wire logic [DIV_W-1:0] clock_divider,
  input  wire logic             rc_tick,
  // Half conversion clock tick
  output logic                  half_tick
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic             next_half_tick;

  // Divider: Fosc/(2*(div+1)) means a half tick every div+1 clocks
  always_comb begin
    next_cnt       = cnt;
    next_half_tick = 1'b0;
    if (!run) begin
      next_cnt = '0;
    end else if (clock_source_select) begin
      next_half_tick = rc_tick;
    end else if (cnt == clock_divider) begin
      next_cnt       = '0;
      next_half_tick = 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt       <= '0;
      half_tick <= 1'b0;
    end else if (ce) begin
      cnt       <= next_cnt;
      half_tick <= next_half_tick;
    end
  end
endmodule : acs_tad_gen
`default_nettype wire

// File: test_adc_conversion_sequencer.sv
/* Self-checking bench for acs_sequencer with far model and checker.
   Assumes acs_pkg, the checker and the far model compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "acs_defines.svh"
module test_adc_conversion_sequencer;
  logic mclk = 1'b0, srst = 1'b1, module_on = 1'b0, go_set = 1'b0;
  logic go_clear = 1'b0, continuous_mode = 1'b0, result_justify = 1'b0;
  logic double_sample_enable = 1'b0, clock_source_select = 1'b0;
  logic conv_irq_enable = 1'b0, conv_done_clear = 1'b0;
  logic sleeping = 1'b0, fire = 1'b0, hit, rc_tick, trigger_pin_remap;
  logic previous_source_select = 1'b0, threshold_clear = 1'b0;
  logic computation_clear = 1'b0;
  logic [15:0] old_prev, err_exp = 16'h0000;
  int nconv = 0;
  logic [2:0] evt = 3'h0;
  logic [5:0] clock_divider = 6'h00;
  logic [4:0] trigger_select = 5'h00;
  logic [9:0] threshold_setpoint = 10'h100, code_in = 10'h000, sar_code;
  logic [21:0] periph_trig;
  logic go_bit, conv_done_flag, computation_pending, threshold_flag;
  logic wake_request, converter_powered;
  logic [15:0] result_reg, previous_result_reg, accumulator_reg;
  logic [15:0] error_value_reg, acc_exp = 16'h0000, old;
  logic [4:0] codes [9] = '{5'h01, 5'h02, 5'h17, 5'h1f, 5'h1d, 5'h1c,
    5'h1e, 5'h00, 5'h18};
  int mismatches = 0, comparisons = 0;
  initial forever #20 mclk = ~mclk;
  acs_sequencer #(.DIV_W(6), .N_PERIPH(22), .INSTR_CYCLES(4)) uut (
    .mclk, .srst, .ce(1'b1), .module_on, .go_set, .go_clear,
    .continuous_mode, .result_justify, .previous_source_select,
    .double_sample_enable, .clock_source_select, .clock_divider,
    .trigger_select, .conv_irq_enable, .conv_done_clear,
    .threshold_clear, .computation_clear, .threshold_setpoint,
    .sleeping, .chan_write_evt(evt[0]), .result_high_read_evt(evt[1]),
    .error_high_read_evt(evt[2]), .trigger_pin_remap, .periph_trig,
    .rc_tick, .sar_code, .go_bit, .conv_done_flag, .computation_pending,
    .threshold_flag, .wake_request, .converter_powered, .result_reg,
    .previous_result_reg, .accumulator_reg, .error_value_reg);
  acs_far_model far (.mclk, .fire, .fire_code(trigger_select), .code_in,
    .trigger_pin_remap, .periph_trig, .rc_tick, .sar_code);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // Bounded wait for the done flag; each completion adds to the sum
  task automatic wait_done(int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge mclk);
      hit = conv_done_flag === 1'b1;
    end
    if (hit) acc_exp = acc_exp + {6'h00, code_in};
  endtask : wait_done
  // Clear the done, threshold and math flags, then a one-cycle go write
  task automatic start;
    conv_done_clear <= 1'b1;
    threshold_clear <= 1'b1;
    computation_clear <= 1'b1;
    @(posedge mclk);
    conv_done_clear <= 1'b0;
    threshold_clear <= 1'b0;
    computation_clear <= 1'b0;
    go_set <= 1'b1;
    @(posedge mclk);
    go_set <= 1'b0;
  endtask : start
  function automatic logic [15:0] placed(logic [9:0] c, logic l);
    placed = l ? {c, 6'h00} : {6'h00, c};
  endfunction : placed
  // Distance of a code from the setpoint
  function automatic logic [9:0] gap(logic [9:0] a, logic [9:0] b);
    gap = (a > b) ? a - b : b - a;
  endfunction : gap
  task automatic convert(logic [9:0] c, logic l);
    logic        ev;
    logic        thr;
    logic [15:0] prev_exp;
    old = result_reg;
    old_prev = previous_result_reg;
    code_in <= c;
    result_justify <= l;
    start;
    wait_done(400);
    ev = !double_sample_enable || nconv % 2 == 1;
    thr = ev && gap(c, threshold_setpoint) > threshold_setpoint;
    if (ev) err_exp = {6'h00, gap(c, threshold_setpoint)};
    if (hit) nconv++;
    prev_exp = previous_source_select ? old_prev : old;
    check("done", {15'h0, hit}, 16'h0001);
    check("result", result_reg, placed(c, l));
    check("previous", previous_result_reg, prev_exp);
    check("error", error_value_reg, err_exp);
    check("threshold", {15'h0, threshold_flag}, {15'h0, thr});
    check("math", {15'h0, computation_pending}, 16'h0001);
    check("go", {15'h0, go_bit}, 16'h0000);
    check("acc", accumulator_reg, acc_exp);
  endtask : convert
  // Fire the source chosen by code, then wait for a completion
  task automatic trig(logic [4:0] code);
    trigger_select <= code;
    conv_done_clear <= 1'b1;
    @(posedge mclk);
    conv_done_clear <= 1'b0;
    fire <= 1'b1;
    evt <= {code == `ACS_TRIG_ERRH_READ, code == `ACS_TRIG_RESH_READ,
      code == `ACS_TRIG_CHAN_WRITE};
    @(posedge mclk);
    evt <= 3'h0;
    repeat (4) @(posedge mclk);
    fire <= 1'b0;
    trigger_select <= `ACS_TRIG_OFF;
    wait_done(200);
  endtask : trig
  initial begin
    void'($urandom(10));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    threshold_setpoint <= 10'($urandom_range(0, 511));
    @(posedge mclk);
    check("reset acc", accumulator_reg, `ACS_RESET_ACC);
    check("reset res", result_reg, {6'h00, `ACS_RESET_RESULT});
    module_on <= 1'b1;
    @(posedge mclk);
    convert(10'h3ff, 1'b1);
    convert(10'h000, 1'b0);
    for (int i = 0; i < 8; i++) begin
      clock_divider <= 6'($urandom_range(0, 2));
      double_sample_enable <= 1'($urandom);
      previous_source_select <= 1'($urandom);
      convert(10'($urandom), 1'($urandom));
    end
    $display("test conversions done");
    old = result_reg;
    code_in <= 10'h155;
    start;
    repeat (6) @(posedge mclk);
    go_clear <= 1'b1;
    @(posedge mclk);
    go_clear <= 1'b0;
    wait_done(200);
    check("abort", {15'h0, hit}, 16'h0000);
    check("kept", result_reg, old);
    module_on <= 1'b0;
    start;
    wait_done(200);
    check("off", {15'h0, hit}, 16'h0000);
    module_on <= 1'b1;
    $display("test abort done");
    for (int i = 0; i < 9; i++) begin
      trig(codes[i]);
      check("trigger", {15'h0, hit}, {15'h0, i < 6});
    end
    sleeping <= 1'b1;
    trig(5'h01);
    check("pending", {15'h0, hit}, 16'h0000);
    sleeping <= 1'b0;
    wait_done(200);
    check("released", {15'h0, hit}, 16'h0001);
    $display("test triggers done");
    clock_source_select <= 1'b1;
    sleeping <= 1'b1;
    conv_irq_enable <= 1'b1;
    start;
    hit = 1'b0;
    for (int i = 0; i < 400 && !hit; i++) begin
      @(posedge mclk);
      hit = wake_request === 1'b1;
    end
    check("wake", {15'h0, hit}, 16'h0001);
    conv_irq_enable <= 1'b0;
    trig(5'h01);
    check("rc sleep", {15'h0, hit}, 16'h0001);
    @(posedge mclk);
    check("powered", {15'h0, converter_powered}, 16'h0000);
    sleeping <= 1'b0;
    clock_source_select <= 1'b0;
    continuous_mode <= 1'b1;
    $display("test sleep done");
    start;
    wait_done(200);
    start;
    wait_done(200);
    check("restart", {15'h0, hit}, 16'h0001);
    check("go held", {15'h0, go_bit}, 16'h0001);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    check("mid reset", {15'h0, go_bit}, 16'h0000);
    check("mid acc", accumulator_reg, `ACS_RESET_ACC);
    $display("test continuous done");
    complete_run;
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    complete_run;
  end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
